// ---- design/ee_slave.sv ----
`timescale 1ns/1ns
module ee_slave #(
    parameter int unsigned TWR_CYC = ee_pkg::TWR_CYC
) (
    // system clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // link sampling clock
    input  wire logic link_clk,
    // two-wire bus pins
    input  wire logic scl,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe,
    // write protect pin
    input  wire logic wp
);

    ee_pkg::ee_link_s r;
    ee_pkg::ee_link_s n;
    ee_pkg::ee_sys_s  s;
    ee_pkg::ee_sys_s  sn;

    logic [7:0] mem [ee_pkg::MEM_N];
    logic [7:0] mem_q;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic       code_ok;
    logic       done_evt;
    logic       req_evt;
    logic       commit;
    logic       mem_we;

    // ---------------- link domain ----------------

    assign mem_q     = mem[r.addr];
    assign scl_rise  = r.scl_s & ~r.scl_p;
    assign scl_fall  = ~r.scl_s & r.scl_p;
    // clock high on both samples, so the data edge is a framing condition
    assign start_det = r.scl_s & r.scl_p & r.sda_p & ~r.sda_s;
    assign stop_det  = r.scl_s & r.scl_p & ~r.sda_p & r.sda_s;
    assign code_ok   = r.shift[7:ee_pkg::DEV_CODE_LSB] == ee_pkg::DEV_CODE;
    assign done_evt  = r.done_s != r.done_p;

    assign sda_o  = 1'b0;
    assign sda_oe = r.oe;

    always_comb begin
        n = r;
        n.scl_m  = scl;
        n.scl_s  = r.scl_m;
        n.scl_p  = r.scl_s;
        n.sda_m  = sda_i;
        n.sda_s  = r.sda_m;
        n.sda_p  = r.sda_s;
        n.done_m = s.done_t;
        n.done_s = r.done_m;
        n.done_p = r.done_s;
        if (done_evt) begin
            n.pend  = 1'b0;
            n.valid = '0;
        end
        if (start_det) begin
            n.st  = ee_pkg::ST_DEV;
            n.cnt = ee_pkg::BIT_START;
            n.oe  = 1'b0;
            if (!r.pend) begin
                n.valid = '0;
            end
        end else if (stop_det) begin
            n.oe = 1'b0;
            n.st = ee_pkg::ST_IDLE;
            if (r.valid != '0 && !r.pend) begin
                n.pend  = 1'b1;
                n.req_t = ~r.req_t;
            end
        end else if (scl_rise) begin
            if (r.cnt == ee_pkg::BIT_ACK) begin
                n.mack = ~r.sda_s;
            end else if (r.st != ee_pkg::ST_RDATA) begin
                n.shift = {r.shift[6:0], r.sda_s};
            end
        end else if (scl_fall && r.st != ee_pkg::ST_IDLE
                     && r.st != ee_pkg::ST_IGNORE) begin
            if (r.cnt == ee_pkg::BIT_LAST) begin
                n.cnt = ee_pkg::BIT_ACK;
                unique case (r.st)
                    ee_pkg::ST_DEV: begin
                        if (code_ok && !r.pend) begin
                            n.oe = 1'b1;
                            n.rw = r.shift[0];
                        end else begin
                            n.st = ee_pkg::ST_IGNORE;
                        end
                    end
                    ee_pkg::ST_WORD: begin
                        n.oe   = 1'b1;
                        n.addr = r.shift;
                    end
                    ee_pkg::ST_WDATA: begin
                        n.oe = 1'b1;
                        n.page[r.addr[2:0]]  = r.shift;
                        n.valid[r.addr[2:0]] = 1'b1;
                        n.base = r.addr[7:3];
                        n.addr = {r.addr[7:3], r.addr[2:0] + 3'h1};
                    end
                    ee_pkg::ST_RDATA: begin
                        n.oe   = 1'b0;
                        n.addr = r.addr + 8'h01;
                    end
                    default: begin
                        n.st = ee_pkg::ST_IGNORE;
                    end
                endcase
            end else if (r.cnt == ee_pkg::BIT_ACK) begin
                n.cnt = ee_pkg::BIT_FIRST;
                n.oe  = 1'b0;
                unique case (r.st)
                    ee_pkg::ST_DEV: begin
                        if (r.rw) begin
                            n.st    = ee_pkg::ST_RDATA;
                            n.shift = mem_q;
                            n.oe    = ~mem_q[7];
                        end else begin
                            n.st = ee_pkg::ST_WORD;
                        end
                    end
                    ee_pkg::ST_WORD: begin
                        n.st = ee_pkg::ST_WDATA;
                    end
                    ee_pkg::ST_WDATA: begin
                        n.st = ee_pkg::ST_WDATA;
                    end
                    ee_pkg::ST_RDATA: begin
                        if (r.mack) begin
                            n.shift = mem_q;
                            n.oe    = ~mem_q[7];
                        end else begin
                            n.st = ee_pkg::ST_IGNORE;
                        end
                    end
                    default: begin
                        n.st = ee_pkg::ST_IGNORE;
                    end
                endcase
            end else begin
                n.cnt = r.cnt + 4'h1;
                if (r.st == ee_pkg::ST_RDATA) begin
                    n.shift = {r.shift[6:0], 1'b0};
                    n.oe    = ~r.shift[6];
                end
            end
        end
    end

    always_ff @(posedge link_clk or posedge reset) begin
        if (reset) begin
            r <= '0;
            r.scl_m <= 1'b1;
            r.scl_s <= 1'b1;
            r.scl_p <= 1'b1;
            r.sda_m <= 1'b1;
            r.sda_s <= 1'b1;
            r.sda_p <= 1'b1;
            r.st    <= ee_pkg::ST_IDLE;
            r.shift <= ee_pkg::SHIFT_RST;
            r.addr  <= ee_pkg::ADDR_RST;
        end else begin
            r <= n;
        end
    end

    // ---------------- system domain ----------------

    assign req_evt = s.req_s != s.req_p;
    assign commit  = s.busy && s.tmr == '0;
    assign mem_we  = commit && !s.wp_s;

    always_comb begin
        sn = s;
        sn.req_m = r.req_t;
        sn.req_s = s.req_m;
        sn.req_p = s.req_s;
        sn.wp_m  = wp;
        sn.wp_s  = s.wp_m;
        if (req_evt && !s.busy) begin
            sn.busy = 1'b1;
            sn.tmr  = ee_pkg::TMR_W'(TWR_CYC - 1);
        end else if (commit) begin
            sn.busy   = 1'b0;
            sn.done_t = ~s.done_t;
        end else if (s.busy) begin
            sn.tmr = s.tmr - ee_pkg::TMR_W'(1);
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= sn;
        end
    end

    // page contents are frozen on the link side while pending
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < ee_pkg::PAGE_N; i++) begin
            if (mem_we && r.valid[i]) begin
                mem[{r.base, ee_pkg::PAGE_W'(i)}] <= r.page[i];
            end
        end
    end

    // ---------------- checks ----------------

    property p_start_frame;
        @(posedge link_clk) disable iff (reset)
        start_det |=> r.st == ee_pkg::ST_DEV && r.cnt == ee_pkg::BIT_START
            && !r.oe;
    endproperty
    a_start_frame: assert property (p_start_frame)
        else $error("start did not open an address phase");

    property p_ack_match;
        @(posedge link_clk) disable iff (reset)
        scl_fall && r.st == ee_pkg::ST_DEV && r.cnt == 4'h7 && code_ok
            && !r.pend && !start_det && !stop_det
        |=> r.oe && r.cnt == 4'h8;
    endproperty
    a_ack_match: assert property (p_ack_match)
        else $error("matching address not acknowledged");

    property p_nack_mismatch;
        @(posedge link_clk) disable iff (reset)
        scl_fall && r.st == ee_pkg::ST_DEV && r.cnt == 4'h7 && !code_ok
            && !start_det && !stop_det
        |=> !r.oe && r.st == ee_pkg::ST_IGNORE;
    endproperty
    a_nack_mismatch: assert property (p_nack_mismatch)
        else $error("mismatching address was not ignored");

    property p_busy_silent;
        @(posedge link_clk) disable iff (reset)
        r.pend |-> !r.oe;
    endproperty
    a_busy_silent: assert property (p_busy_silent)
        else $error("data line driven during rewrite");

    property p_read_stop;
        @(posedge link_clk) disable iff (reset)
        stop_det && r.st == ee_pkg::ST_RDATA
        |=> r.st == ee_pkg::ST_IDLE && !r.oe ##1 !r.oe;
    endproperty
    a_read_stop: assert property (p_read_stop)
        else $error("read not aborted by stop");

    property p_write_stop;
        @(posedge link_clk) disable iff (reset)
        stop_det && r.valid != '0 && !r.pend && !done_evt
        |=> r.pend && r.req_t != $past(r.req_t);
    endproperty
    a_write_stop: assert property (p_write_stop)
        else $error("stop after write data did not launch rewrite");

    property p_page_wrap;
        @(posedge link_clk) disable iff (reset)
        scl_fall && r.st == ee_pkg::ST_WDATA && r.cnt == 4'h7
            && !start_det && !stop_det
        |=> r.addr[7:3] == $past(r.addr[7:3])
            && r.addr[2:0] == $past(r.addr[2:0]) + 3'h1;
    endproperty
    a_page_wrap: assert property (p_page_wrap)
        else $error("write address left its page");

    property p_read_incr;
        @(posedge link_clk) disable iff (reset)
        scl_fall && r.st == ee_pkg::ST_RDATA && r.cnt == 4'h7
            && !start_det && !stop_det
        |=> r.addr == $past(r.addr) + 8'h01 && !r.oe;
    endproperty
    a_read_incr: assert property (p_read_incr)
        else $error("read counter did not advance");

    property p_rewrite_hold;
        @(posedge sys_clk) disable iff (reset)
        req_evt && !s.busy |=> s.busy [*8];
    endproperty
    a_rewrite_hold: assert property (p_rewrite_hold)
        else $error("rewrite ended too early");

    property p_protect;
        @(posedge sys_clk) disable iff (reset)
        s.wp_s |-> !mem_we;
    endproperty
    a_protect: assert property (p_protect)
        else $error("array written while protected");

endmodule

// ---- inc/ee_pkg.sv ----
package ee_pkg;

    // bus framing
    localparam logic [3:0] DEV_CODE     = 4'ha;
    localparam int         DEV_CODE_LSB = 4;
    localparam logic [3:0] BIT_LAST     = 4'h7;
    localparam logic [3:0] BIT_ACK      = 4'h8;
    localparam logic [3:0] BIT_FIRST    = 4'h0;
    // the start's own clock fall wraps this to BIT_FIRST
    localparam logic [3:0] BIT_START    = 4'hf;

    // array geometry
    localparam int ADDR_W  = 8;
    localparam int MEM_N   = 256;
    localparam int PAGE_N  = 8;
    localparam int PAGE_W  = 3;
    localparam int BASE_W  = ADDR_W - PAGE_W;

    // rewrite time
    localparam int SYS_CLK_HZ = 10_000_000;
    localparam int T_WR_MS    = 10;
    localparam int TWR_CYC    = T_WR_MS * (SYS_CLK_HZ / 1000);
    localparam int TMR_W      = 17;

    // reset values
    localparam logic [7:0] SHIFT_RST = 8'h00;
    localparam logic [7:0] ADDR_RST  = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_WORD,
        ST_WDATA,
        ST_RDATA,
        ST_IGNORE
    } ee_state_e;

    // link-side state
    typedef struct packed {
        logic                       scl_m;
        logic                       scl_s;
        logic                       scl_p;
        logic                       sda_m;
        logic                       sda_s;
        logic                       sda_p;
        logic                       done_m;
        logic                       done_s;
        logic                       done_p;
        ee_state_e                  st;
        logic [3:0]                 cnt;
        logic [7:0]                 shift;
        logic                       rw;
        logic                       mack;
        logic [ADDR_W-1:0]          addr;
        logic [PAGE_N-1:0][7:0]     page;
        logic [PAGE_N-1:0]          valid;
        logic [BASE_W-1:0]          base;
        logic                       pend;
        logic                       req_t;
        logic                       oe;
    } ee_link_s;

    // system-side state
    typedef struct packed {
        logic                       req_m;
        logic                       req_s;
        logic                       req_p;
        logic                       wp_m;
        logic                       wp_s;
        logic                       busy;
        logic [TMR_W-1:0]           tmr;
        logic                       done_t;
    } ee_sys_s;

endpackage

// ---- sim/ee_bus_master.sv ----
`timescale 1ns/1ns
module ee_bus_master (
    // clock
    input  wire logic sys_clk,
    // bus
    input  wire logic sda,
    output logic      scl,
    output logic      pull
);
    // idle bus: clock high, data released
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end

    // data moves only in the low half of the clock
    task automatic bit_cell(input logic b, output logic r);
        @(posedge sys_clk);
        pull <= ~b;
        @(posedge sys_clk);
        scl <= 1'b1;
        @(posedge sys_clk);
        r = sda;
        scl <= 1'b0;
    endtask

    task automatic start_cond();
        @(posedge sys_clk);
        pull <= 1'b0;
        @(posedge sys_clk);
        scl <= 1'b1;
        @(posedge sys_clk);
        pull <= 1'b1;
        @(posedge sys_clk);
        scl <= 1'b0;
    endtask

    task automatic stop_cond();
        @(posedge sys_clk);
        pull <= 1'b1;
        @(posedge sys_clk);
        scl <= 1'b1;
        @(posedge sys_clk);
        pull <= 1'b0;
        @(posedge sys_clk);
    endtask

    // msb first, ninth clock released for the answer
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_cell(d[i], r);
        end
        bit_cell(1'b1, r);
        ack = (r === 1'b0);
    endtask

    // last byte of a read is left unacknowledged
    task automatic recv_byte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_cell(1'b1, r);
            d[i] = r;
        end
        bit_cell(~more, r);
    endtask

    // read-direction polling; wp stays put meanwhile
    task automatic poll(output int tries, output logic [7:0] d);
        logic ack;
        tries = 0;
        ack = 1'b0;
        d = 8'h00;
        while (!ack && tries < 40) begin
            start_cond();
            send_byte(8'hab, ack);
            tries++;
            if (ack) begin
                recv_byte(1'b0, d);
            end
            stop_cond();
        end
    endtask
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    localparam int unsigned TWR = 200;
    logic       sys_clk;
    logic       link_clk;
    logic       reset;
    logic       wp;
    logic       scl;
    logic       pull;
    logic       sda;
    logic       sda_o;
    logic       sda_oe;
    logic [7:0] exp_mem [256];
    int         err_total;
    int         checks;
    int         cycles;

    assign sda = ((sda_oe & ~sda_o) | pull) ? 1'b0 : 1'b1;

    ee_slave #(.TWR_CYC(TWR)) ee_slave_inst (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .link_clk (link_clk),
        .scl      (scl),
        .sda_i    (sda),
        .sda_o    (sda_o),
        .sda_oe   (sda_oe),
        .wp       (wp)
    );

    ee_bus_master ee_bus_master_inst (
        .sys_clk (sys_clk),
        .sda     (sda),
        .scl     (scl),
        .pull    (pull)
    );

    initial sys_clk = 1'b0;
    always #50 sys_clk = ~sys_clk;
    // odd offset keeps link edges off the system edges
    initial begin
        link_clk = 1'b0;
        #5;
        forever #6 link_clk = ~link_clk;
    end

    task automatic end_of_test();
        $display("counts: %0d compares, %0d mismatches", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task automatic write_seq(input logic [7:0] a, input logic [7:0] d[$]);
        logic ack;
        ee_bus_master_inst.start_cond();
        ee_bus_master_inst.send_byte(8'hae, ack);
        chk(ack, "write address not acked");
        ee_bus_master_inst.send_byte(a, ack);
        chk(ack, "word address not acked");
        foreach (d[i]) begin
            ee_bus_master_inst.send_byte(d[i], ack);
            chk(ack, "data byte not acked");
        end
        ee_bus_master_inst.stop_cond();
    endtask

    task automatic read_seq(input logic [7:0] a, input int n);
        logic       ack;
        logic [7:0] b;
        ee_bus_master_inst.start_cond();
        ee_bus_master_inst.send_byte(8'hae, ack);
        chk(ack, "dummy write not acked");
        ee_bus_master_inst.send_byte(a, ack);
        chk(ack, "dummy word address not acked");
        ee_bus_master_inst.start_cond();
        ee_bus_master_inst.send_byte(8'ha5, ack);
        chk(ack, "read address not acked");
        for (int i = 0; i < n; i++) begin
            ee_bus_master_inst.recv_byte(i < n - 1, b);
            chk(b === exp_mem[8'(a + i)], "read data wrong");
        end
        ee_bus_master_inst.stop_cond();
        chk(sda_oe === 1'b0, "data line held after stop");
    endtask

    task automatic wait_ready(input logic [7:0] a);
        int         tries;
        logic [7:0] d;
        ee_bus_master_inst.poll(tries, d);
        chk(tries > 1, "no busy refusal after stop");
        chk(tries < 40, "rewrite never ended");
        chk(d === exp_mem[a], "current address read wrong");
    endtask

    task automatic t_page_wrap();
        logic [7:0] q[$];
        for (int i = 0; i < 10; i++) begin
            q.push_back(8'(8'h10 + i));
            exp_mem[{5'h00, 3'(6 + i)}] = 8'(8'h10 + i);
        end
        write_seq(8'h06, q);
        wait_ready(8'h00);
        read_seq(8'h00, 8);
        $display("test page_wrap done");
    endtask

    task automatic t_seq_wrap();
        logic [7:0] q[$];
        for (int i = 0; i < 8; i++) begin
            q.push_back(8'(8'hc0 + i));
            exp_mem[8'(8'hf8 + i)] = 8'(8'hc0 + i);
        end
        write_seq(8'hf8, q);
        wait_ready(8'hf8);
        read_seq(8'hfe, 4);
        $display("test seq_wrap done");
    endtask

    task automatic t_protect();
        logic [7:0] q[$];
        q.push_back(8'h5a);
        @(posedge sys_clk);
        wp <= 1'b1;
        write_seq(8'h05, q);
        wait_ready(8'h06);
        @(posedge sys_clk);
        wp <= 1'b0;
        read_seq(8'h05, 1);
        $display("test protect done");
    endtask

    task automatic t_read_abort();
        logic       ack;
        logic [7:0] b;
        ee_bus_master_inst.start_cond();
        ee_bus_master_inst.send_byte(8'hae, ack);
        chk(ack, "dummy write not acked");
        ee_bus_master_inst.send_byte(8'hf9, ack);
        chk(ack, "dummy word address not acked");
        ee_bus_master_inst.start_cond();
        ee_bus_master_inst.send_byte(8'ha5, ack);
        chk(ack, "read address not acked");
        // first data bit is a one, so the bus is free for a stop
        ee_bus_master_inst.stop_cond();
        chk(sda_oe === 1'b0, "data line held after aborted read");
        ee_bus_master_inst.start_cond();
        ee_bus_master_inst.send_byte(8'ha5, ack);
        chk(ack, "current read not acked");
        ee_bus_master_inst.recv_byte(1'b0, b);
        chk(b === exp_mem[8'hf9], "aborted read moved counter");
        ee_bus_master_inst.stop_cond();
        $display("test read_abort done");
    endtask

    task automatic t_bad_code();
        logic       ack;
        logic [7:0] codes[3];
        codes = '{8'h5e, 8'hbe, 8'h2f};
        foreach (codes[i]) begin
            ee_bus_master_inst.start_cond();
            ee_bus_master_inst.send_byte(codes[i], ack);
            chk(!ack, "foreign code acked");
            ee_bus_master_inst.send_byte(8'h00, ack);
            chk(!ack, "byte after foreign code acked");
            ee_bus_master_inst.stop_cond();
        end
        read_seq(8'h06, 2);
        $display("test bad_code done");
    endtask

    initial begin
        reset = 1'b1;
        wp = 1'b0;
        err_total = 0;
        checks = 0;
        cycles = 0;
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (2) @(posedge sys_clk);
        t_page_wrap();
        t_seq_wrap();
        t_read_abort();
        t_protect();
        t_bad_code();
        end_of_test();
    end
endmodule
